//--- charge_profile_defines.svh
`ifndef CHARGE_PROFILE_DEFINES_SVH
`define CHARGE_PROFILE_DEFINES_SVH

// timing
`define CLK_FREQ_HZ      50000000
`define TICK_PERIOD_S    1

// register offsets
`define OFS_FIRST        8'h1F
`define OFS_T1           8'h1F
`define OFS_T2           8'h20
`define OFS_T3           8'h21
`define OFS_T4           8'h22
`define OFS_T5           8'h23
`define OFS_T6           8'h24
`define OFS_VOLT_HOT     8'h25
`define OFS_VOLT_MID     8'h26
`define OFS_CURR_HOT     8'h27
`define OFS_CURR_MID     8'h28
`define OFS_CFG          8'h29
`define OFS_ABS_ADD      8'h2A
`define OFS_ABS_TIME     8'h2B
`define OFS_EQ_ADD       8'h2C
`define OFS_EQ_TIME      8'h2D
`define OFS_RECHARGE     8'h2E
`define OFS_RSVD         8'h2F
`define OFS_TMR_CHG      8'h30
`define OFS_TMR_CV       8'h31
`define OFS_TMR_ABS      8'h32

// reset values
`define RST_T1           16'h3F00
`define RST_T2           16'h372A
`define RST_T3           16'h1F27
`define RST_T4           16'h1BCC
`define RST_T5           16'h18B9
`define RST_T6           16'h136D
`define RST_VOLT_HOT     16'h0000
`define RST_VOLT_MID     16'h0000
`define RST_CURR_HOT     16'h01EF
`define RST_CURR_MID     16'h7FEF
`define RST_CFG          16'h0000
`define RST_ABS_ADD      16'h0000
`define RST_ABS_TIME     16'h0000
`define RST_EQ_ADD       16'h002A
`define RST_EQ_TIME      16'h0E10
`define RST_RECHARGE     16'h4410

// field positions
`define FLD_HI_LSB       10
`define FLD_MID_LSB      5
`define FLD_LO_LSB       0
`define CFG_CX_BIT       2
`define CFG_TCOMP_BIT    1
`define CFG_JEITA_BIT    0

// writable bits
`define MASK_CODES2      16'h03FF
`define MASK_CODES3      16'h7FFF
`define MASK_CFG         16'h0007
`define MASK_ADDER       16'h003F

`endif

//--- charge_profile_pkg.sv
package charge_profile_pkg;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_SUB   = 3'b010,
      ST_WLO   = 3'b011,
      ST_WHI   = 3'b100,
      ST_ACK   = 3'b101,
      ST_RDATA = 3'b110,
      ST_RACK  = 3'b111
   } i2c_state_t;

endpackage

//--- elapsed_seconds_timer.sv
`timescale 1ns/1ns
module elapsed_seconds_timer
   import charge_profile_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         tick,
   input  wire logic         run,
   output logic [W-1:0]      count
);

   typedef struct packed {
      logic [W-1:0] cnt;
   } tmr_state_t;

   tmr_state_t s_q;
   tmr_state_t s_d;

   always_comb begin
      s_d = s_q;
      // clear, count, saturate
      // phase left: count restarts with the next entry
      if (!run) begin
         s_d.cnt = '0;
      end else if (tick && s_q.cnt != {W{1'b1}}) begin
         s_d.cnt = s_q.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign count = s_q.cnt;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   AST_TMR_SATURATE: assert property (
      (run && tick && s_q.cnt == {W{1'b1}}) |=> s_q.cnt == {W{1'b1}})
      else $error("elapsed timer wrapped past its maximum");

   AST_TMR_COUNT: assert property (
      (run && tick && s_q.cnt != {W{1'b1}}) ##1 run |-> s_q.cnt == $past(s_q.cnt) + 1'b1)
      else $error("elapsed timer missed a second");

   AST_TMR_CLEAR: assert property (
      !run |=> s_q.cnt == '0)
      else $error("elapsed timer not cleared outside its phase");

endmodule

//--- charge_profile_config_regs.sv
`timescale 1ns/1ns
`include "charge_profile_defines.svh"
module charge_profile_config_regs
   import charge_profile_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR    = 7'h2A,  // arbitrary value
   parameter int         TICK_CYCLES = `TICK_PERIOD_S * `CLK_FREQ_HZ
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         scl,
   input  wire logic         sda_in,
   output logic              sda_out,
   output logic              sda_oe,
   input  wire logic [15:0]  ntc_ratio,
   input  wire logic         charging,
   input  wire logic         cv_active,
   input  wire logic         absorb_active,
   output logic [2:0]        region,
   output logic              charge_off,
   output logic [4:0]        vcharge_code,
   output logic [5:0]        icharge_mv,
   output logic              en_c_over_x_term,
   output logic              en_lead_acid_temp_comp,
   output logic              en_jeita,
   output logic [5:0]        absorb_adder,
   output logic [15:0]       absorb_time_limit,
   output logic [5:0]        equalize_adder,
   output logic [15:0]       equalize_duration,
   output logic [15:0]       recharge_level
);

   localparam int NREG = 16;
   localparam int NTMR = 3;

   localparam int I_VOLT_HOT = int'(`OFS_VOLT_HOT - `OFS_FIRST);
   localparam int I_VOLT_MID = int'(`OFS_VOLT_MID - `OFS_FIRST);
   localparam int I_CURR_HOT = int'(`OFS_CURR_HOT - `OFS_FIRST);
   localparam int I_CURR_MID = int'(`OFS_CURR_MID - `OFS_FIRST);
   localparam int I_CFG      = int'(`OFS_CFG - `OFS_FIRST);
   localparam int I_ABS_ADD  = int'(`OFS_ABS_ADD - `OFS_FIRST);
   localparam int I_ABS_TIME = int'(`OFS_ABS_TIME - `OFS_FIRST);
   localparam int I_EQ_ADD   = int'(`OFS_EQ_ADD - `OFS_FIRST);
   localparam int I_EQ_TIME  = int'(`OFS_EQ_TIME - `OFS_FIRST);
   localparam int I_RECHARGE = int'(`OFS_RECHARGE - `OFS_FIRST);

   localparam logic [NREG-1:0][15:0] REG_RST = {
      `RST_RECHARGE,
      `RST_EQ_TIME,
      `RST_EQ_ADD,
      `RST_ABS_TIME,
      `RST_ABS_ADD,
      `RST_CFG,
      `RST_CURR_MID,
      `RST_CURR_HOT,
      `RST_VOLT_MID,
      `RST_VOLT_HOT,
      `RST_T6,
      `RST_T5,
      `RST_T4,
      `RST_T3,
      `RST_T2,
      `RST_T1
   };

   typedef struct packed {
      i2c_state_t              st;
      i2c_state_t              nxt;
      logic                    scl_q;
      logic                    sda_q;
      logic [3:0]              cnt;
      logic [7:0]              sh;
      logic [7:0]              sub;
      logic [7:0]              wlo;
      logic [15:0]             tx;
      logic                    hi;
      logic                    nack;
      logic                    oe;
      logic [31:0]             div;
      logic                    tick;
      logic [NREG-1:0][15:0]   regs;
      logic [2:0]              region;
      logic                    off;
      logic [4:0]              vcode;
      logic [5:0]              imv;
   } state_t;

   localparam state_t RST_S = '{
      st:     ST_IDLE,
      nxt:    ST_IDLE,
      scl_q:  1'b1,
      sda_q:  1'b1,
      cnt:    4'h0,
      sh:     8'h00,
      sub:    8'h00,
      wlo:    8'h00,
      tx:     16'h0000,
      hi:     1'b0,
      nack:   1'b0,
      oe:     1'b0,
      div:    32'h0000_0000,
      tick:   1'b0,
      regs:   REG_RST,
      region: 3'h1,
      off:    1'b0,
      vcode:  5'h00,
      imv:    6'h01
   };

   state_t              s_q;
   state_t              s_d;
   logic                scl_rise;
   logic                scl_fall;
   logic                start;
   logic                stop;
   logic                wr_en;
   logic [15:0]         wr_data;
   logic [NTMR-1:0]     tmr_run;
   logic [NTMR-1:0][15:0] tmr_cnt;

   // scl and sda are taken as already synchronous to clk
   assign scl_rise = scl & ~s_q.scl_q;
   assign scl_fall = ~scl & s_q.scl_q;
   assign start    = scl & s_q.scl_q & s_q.sda_q & ~sda_in;
   assign stop     = scl & s_q.scl_q & ~s_q.sda_q & sda_in;
   assign wr_data  = {s_q.sh, s_q.wlo};

   function automatic logic in_bank(input logic [7:0] a);
      return (a >= `OFS_FIRST) && (a <= `OFS_RECHARGE);
   endfunction

   function automatic logic [3:0] bank_idx(input logic [7:0] a);
      logic [7:0] d;
      d = a - `OFS_FIRST;
      return d[3:0];
   endfunction

   function automatic logic [15:0] wmask(input logic [7:0] a);
      logic [15:0] m;
      m = 16'hFFFF;
      case (a)
         `OFS_VOLT_HOT, `OFS_CURR_HOT: m = `MASK_CODES2;
         `OFS_VOLT_MID, `OFS_CURR_MID: m = `MASK_CODES3;
         `OFS_CFG:                     m = `MASK_CFG;
         `OFS_ABS_ADD, `OFS_EQ_ADD:    m = `MASK_ADDER;
         default:                      m = 16'hFFFF;
      endcase
      return m;
   endfunction

   // region 2 uses the low field, 3 the middle, 4 the high of the mid word
   function automatic logic [4:0] pick(input logic [15:0] hot,
                                      input logic [15:0] mid,
                                      input logic [2:0]  rg);
      logic [4:0] c;
      c = 5'h00;
      case (rg)
         3'h6:    c = hot[`FLD_MID_LSB +: 5];
         3'h5:    c = hot[`FLD_LO_LSB +: 5];
         3'h4:    c = mid[`FLD_HI_LSB +: 5];
         3'h3:    c = mid[`FLD_MID_LSB +: 5];
         3'h2:    c = mid[`FLD_LO_LSB +: 5];
         default: c = 5'h00;
      endcase
      return c;
   endfunction

   always_comb begin
      logic [15:0] rd;
      logic [7:0]  txb;
      logic [2:0]  rg;
      rd    = 16'h0000;
      txb   = s_q.hi ? s_q.tx[15:8] : s_q.tx[7:0];
      rg    = 3'h1;
      s_d   = s_q;
      wr_en = 1'b0;
      s_d.scl_q = scl;
      s_d.sda_q = sda_in;

      // one-second enable
      s_d.tick = 1'b0;
      if (s_q.div == 32'(TICK_CYCLES - 1)) begin
         s_d.div  = 32'h0000_0000;
         s_d.tick = 1'b1;
      end else begin
         s_d.div = s_q.div + 32'h0000_0001;
      end

      if (in_bank(s_q.sub)) begin
         rd = s_q.regs[bank_idx(s_q.sub)];
      end else if (s_q.sub == `OFS_TMR_CHG) begin
         rd = tmr_cnt[0];
      end else if (s_q.sub == `OFS_TMR_CV) begin
         rd = tmr_cnt[1];
      end else if (s_q.sub == `OFS_TMR_ABS) begin
         rd = tmr_cnt[2];
      end

      if (stop) begin
         s_d.st = ST_IDLE;
         s_d.oe = 1'b0;
      end else if (start) begin
         s_d.st  = ST_ADDR;
         s_d.cnt = 4'h0;
         s_d.oe  = 1'b0;
      end else begin
         unique case (s_q.st)
            ST_IDLE: begin
            end
            ST_ADDR, ST_SUB, ST_WLO, ST_WHI: begin
               if (scl_rise) begin
                  s_d.sh  = {s_q.sh[6:0], sda_in};
                  s_d.cnt = s_q.cnt + 4'h1;
               end else if (scl_fall && s_q.cnt == 4'h8) begin
                  s_d.cnt = 4'h0;
                  s_d.oe  = 1'b1;
                  s_d.st  = ST_ACK;
                  if (s_q.st == ST_ADDR) begin
                     if (s_q.sh[7:1] == DEV_ADDR) begin
                        s_d.nxt = s_q.sh[0] ? ST_RDATA : ST_SUB;
                     end else begin
                        // another target: stay off the bus until next start
                        s_d.oe = 1'b0;
                        s_d.st = ST_IDLE;
                     end
                  end else if (s_q.st == ST_SUB) begin
                     s_d.sub = s_q.sh;
                     s_d.nxt = ST_WLO;
                  end else if (s_q.st == ST_WLO) begin
                     s_d.wlo = s_q.sh;
                     s_d.nxt = ST_WHI;
                  end else begin
                     wr_en   = 1'b1;
                     s_d.nxt = ST_IDLE;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  s_d.st = s_q.nxt;
                  s_d.oe = 1'b0;
                  if (s_q.nxt == ST_RDATA) begin
                     // whole word captured once so both bytes agree
                     s_d.tx = rd;
                     s_d.hi = 1'b0;
                     s_d.oe = ~rd[7];
                  end
               end
            end
            ST_RDATA: begin
               if (scl_rise) begin
                  s_d.cnt = s_q.cnt + 4'h1;
               end else if (scl_fall) begin
                  if (s_q.cnt == 4'h8) begin
                     s_d.oe = 1'b0;
                     s_d.st = ST_RACK;
                  end else begin
                     s_d.oe = ~txb[3'(4'h7 - s_q.cnt)];
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  s_d.nack = sda_in;
               end else if (scl_fall) begin
                  if (s_q.nack || s_q.hi) begin
                     s_d.st = ST_IDLE;
                  end else begin
                     s_d.hi  = 1'b1;
                     s_d.cnt = 4'h0;
                     s_d.oe  = ~s_q.tx[15];
                     s_d.st  = ST_RDATA;
                  end
               end
            end
         endcase
      end

      // writes outside the bank are dropped
      if (wr_en && in_bank(s_q.sub)) begin
         s_d.regs[bank_idx(s_q.sub)] = wr_data & wmask(s_q.sub);
      end

      // thresholds fall with temperature; the last one passed wins
      for (int k = 0; k < 6; k++) begin
         if (ntc_ratio <= s_q.regs[k]) begin
            rg = 3'(k + 2);
         end
      end
      s_d.region = rg;
      s_d.off    = s_q.regs[I_CFG][`CFG_JEITA_BIT] && (rg == 3'h1 || rg == 3'h7);
      s_d.vcode  = pick(s_q.regs[I_VOLT_HOT], s_q.regs[I_VOLT_MID], rg);
      s_d.imv    = {1'b0, pick(s_q.regs[I_CURR_HOT], s_q.regs[I_CURR_MID], rg)} + 6'h01;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= RST_S;
      end else begin
         s_q <= s_d;
      end
   end

   assign tmr_run = {absorb_active, cv_active, charging};

   generate
      for (genvar t = 0; t < NTMR; t++) begin : g_tmr
         elapsed_seconds_timer #(
            .W (16)
         ) i_elapsed_seconds_timer (
            .clk   (clk),
            .nrst  (nrst),
            .tick  (s_q.tick),
            .run   (tmr_run[t]),
            .count (tmr_cnt[t])
         );
      end
   endgenerate

   // open drain: only ever pulls low
   assign sda_out                = 1'b0;
   assign sda_oe                 = s_q.oe;
   assign region                 = s_q.region;
   assign charge_off             = s_q.off;
   assign vcharge_code           = s_q.vcode;
   assign icharge_mv             = s_q.imv;
   assign en_c_over_x_term       = s_q.regs[I_CFG][`CFG_CX_BIT];
   assign en_lead_acid_temp_comp = s_q.regs[I_CFG][`CFG_TCOMP_BIT];
   assign en_jeita               = s_q.regs[I_CFG][`CFG_JEITA_BIT];
   assign absorb_adder           = s_q.regs[I_ABS_ADD][5:0];
   assign absorb_time_limit      = s_q.regs[I_ABS_TIME];
   assign equalize_adder         = s_q.regs[I_EQ_ADD][5:0];
   assign equalize_duration      = s_q.regs[I_EQ_TIME];
   assign recharge_level         = s_q.regs[I_RECHARGE];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   AST_T2_WRITE: assert property (
      (wr_en && s_q.sub == `OFS_T2) |=> s_q.regs[1] == $past(wr_data))
      else $error("threshold 3/2 write not stored");

   AST_THRESH_WRITE: assert property (
      (wr_en && s_q.sub >= `OFS_T3 && s_q.sub <= `OFS_T6)
      |=> s_q.regs[$past(bank_idx(s_q.sub))] == $past(wr_data))
      else $error("threshold write not stored");

   AST_T1_WRITE: assert property (
      (wr_en && s_q.sub == `OFS_T1) |=> s_q.regs[0] == $past(wr_data))
      else $error("threshold 2/1 write not stored");

   AST_VOLT_HOT_RSVD: assert property (
      s_q.regs[I_VOLT_HOT][15:10] == 6'h00)
      else $error("reserved bits of hot voltage codes set");

   AST_VOLT_MID_RSVD: assert property (
      s_q.regs[I_VOLT_MID][15] == 1'b0)
      else $error("reserved bit of mid voltage codes set");

   AST_CURR_HOT_RSVD: assert property (
      s_q.regs[I_CURR_HOT][15:10] == 6'h00)
      else $error("reserved bits of hot current codes set");

   AST_CURR_MID_RSVD: assert property (
      s_q.regs[I_CURR_MID][15] == 1'b0)
      else $error("reserved bit of mid current codes set");

   AST_CFG_RSVD: assert property (
      (wr_en && s_q.sub == `OFS_CFG)
      |=> s_q.regs[I_CFG] == ($past(wr_data) & `MASK_CFG))
      else $error("config write not masked to three enables");

   AST_ADDER_RSVD: assert property (
      s_q.regs[I_ABS_ADD][15:6] == 10'h000)
      else $error("absorb adder reserved bits set");

   AST_ABS_LIMIT_WRITE: assert property (
      (wr_en && s_q.sub == `OFS_ABS_TIME) |=> absorb_time_limit == $past(wr_data))
      else $error("absorb time limit write not stored");

   AST_EQ_RSVD: assert property (
      s_q.regs[I_EQ_ADD][15:6] == 10'h000)
      else $error("equalize adder reserved bits set");

   AST_CURR_REGION2: assert property (
      s_q.region == 3'h2 |-> s_q.imv == {1'b0, $past(s_q.regs[I_CURR_MID][4:0])} + 6'h01)
      else $error("region 2 current target not code plus one");

   AST_RSVD_READ: assert property (
      (s_q.st == ST_ACK && s_q.nxt == ST_RDATA && scl_fall && !start && !stop
       && s_q.sub == `OFS_RSVD) |=> s_q.tx == 16'h0000)
      else $error("reserved address did not read zero");

   AST_TIMER_NO_WRITE: assert property (
      (wr_en && s_q.sub >= `OFS_RSVD) |=> s_q.regs == $past(s_q.regs))
      else $error("write outside the bank changed a register");

endmodule

//--- i2c_host_model.sv
`timescale 1ns/1ns
module i2c_host_model #(
   parameter logic [6:0] DEV = 7'h2A
) (
   input  wire logic        clk,
   input  wire logic        sda_line,
   output logic             scl,
   output logic             sda_pull,
   output logic [15:0]      rd_word,
   output logic             rd_strobe
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
      rd_word = 16'h0000;
      rd_strobe = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // release lets the pull-up win, so a host 1 never fights the slave
   task automatic bit_io(input logic b, output logic s);
      sda_pull = ~b;
      wt(2);
      scl = 1'b1;
      wt(2);
      s = sda_line;
      wt(2);
      scl = 1'b0;
      wt(2);
   endtask
   task automatic start();
      sda_pull = 1'b0;
      wt(2);
      scl = 1'b1;
      wt(4);
      sda_pull = 1'b1;
      wt(4);
      scl = 1'b0;
      wt(2);
   endtask
   task automatic stop();
      sda_pull = 1'b1;
      wt(2);
      scl = 1'b1;
      wt(4);
      sda_pull = 1'b0;
      wt(4);
   endtask
   task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx,
                          input logic ack, output logic nak);
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
      bit_io(ack, nak);
   endtask
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] sub,
                            input logic [15:0] d, output logic nak);
      logic [7:0] rx;
      logic       n;
      start();
      byte_io({dev, 1'b0}, rx, 1'b1, nak);
      if (nak === 1'b0) begin
         byte_io(sub, rx, 1'b1, n);
         // low byte first
         byte_io(d[7:0], rx, 1'b1, n);
         byte_io(d[15:8], rx, 1'b1, n);
      end
      stop();
   endtask
   task automatic read_reg(input logic [7:0] sub);
      logic [7:0] lo;
      logic [7:0] hi;
      logic       n;
      start();
      byte_io({DEV, 1'b0}, lo, 1'b1, n);
      byte_io(sub, lo, 1'b1, n);
      start();
      byte_io({DEV, 1'b1}, lo, 1'b1, n);
      byte_io(8'hFF, lo, 1'b0, n);
      byte_io(8'hFF, hi, 1'b1, n);
      stop();
      rd_word = {hi, lo};
      rd_strobe = 1'b1;
      wt(1);
      rd_strobe = 1'b0;
   endtask
endmodule

//--- tb_charge_profile_config_regs.sv
`timescale 1ns/1ns
module tb_charge_profile_config_regs;
   import charge_profile_pkg::*;
   localparam logic [6:0] DEV = 7'h2A;  // arbitrary value
   localparam logic [15:0] RST [17] = '{16'h3F00, 16'h372A, 16'h1F27, 16'h1BCC, 16'h18B9,
      16'h136D, 16'h0000, 16'h0000, 16'h01EF, 16'h7FEF, 16'h0000, 16'h0000, 16'h0000,
      16'h002A, 16'h0E10, 16'h4410, 16'h0000};
   localparam logic [15:0] MSK [16] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
      16'hFFFF, 16'h03FF, 16'h7FFF, 16'h03FF, 16'h7FFF, 16'h0007, 16'h003F, 16'hFFFF,
      16'h003F, 16'hFFFF, 16'hFFFF};
   logic        clk = 1'b0;
   logic        nrst;
   logic        scl;
   logic        sda_pull;
   logic        sda_out;
   logic        sda_oe;
   logic        sda_line;
   logic [15:0] ntc_ratio;
   logic        charging;
   logic        cv_active;
   logic        absorb_active;
   logic [2:0]  region;
   logic [4:0]  vcode;
   logic [5:0]  imv;
   logic        en_cx;
   logic        en_tc;
   logic        en_jeita;
   logic [5:0]  abs_add;
   logic [15:0] abs_lim;
   logic [15:0] eq_dur;
   logic [5:0]  eq_add;
   logic [15:0] rchg;
   logic        chg_off;
   logic [15:0] thr [6];
   logic [15:0] rd_word;
   logic        rd_strobe;
   logic [15:0] exp_q [$];
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          seed = 32'hb828;
   int          cyc = 0;

   always #10 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   assign sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_pull;

   charge_profile_config_regs #(.DEV_ADDR(DEV), .TICK_CYCLES(1)) i_charge_profile_config_regs (
      .clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .ntc_ratio(ntc_ratio), .charging(charging), .cv_active(cv_active),
      .absorb_active(absorb_active), .region(region), .charge_off(chg_off), .vcharge_code(vcode),
      .icharge_mv(imv), .en_c_over_x_term(en_cx), .en_lead_acid_temp_comp(en_tc),
      .en_jeita(en_jeita), .absorb_adder(abs_add), .absorb_time_limit(abs_lim),
      .equalize_adder(eq_add), .equalize_duration(eq_dur), .recharge_level(rchg));
   i2c_host_model #(.DEV(DEV)) i_i2c_host_model (.clk(clk), .sda_line(sda_line), .scl(scl),
      .sda_pull(sda_pull), .rd_word(rd_word), .rd_strobe(rd_strobe));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   function automatic logic [2:0] exp_region(input logic [15:0] r);
      exp_region = 3'h1;
      for (int k = 0; k < 6; k++) if (r <= thr[k]) exp_region = 3'(k + 2);
   endfunction
   // regions 6 and 5 sit in the hot word, 4 to 2 in the mid word
   function automatic logic [4:0] field(input logic [15:0] hot, input logic [15:0] mid,
                                        input logic [2:0] rg);
      field = 5'h00;
      case (rg)
         3'h6: field = hot[9:5];
         3'h5: field = hot[4:0];
         3'h4: field = mid[14:10];
         3'h3: field = mid[9:5];
         3'h2: field = mid[4:0];
      endcase
   endfunction

   always @(posedge clk) begin
      if (rd_strobe === 1'b1) begin
         check("read word", rd_word, exp_q.pop_front());
      end
   end

   initial begin
      logic [15:0] wv [16];
      logic [7:0]  odd [4];
      logic        nak;
      logic [2:0]  rg;
      nrst = 1'b0;
      ntc_ratio = 16'h0000;
      charging = 1'b0;
      cv_active = 1'b0;
      absorb_active = 1'b0;
      odd = '{8'h2F, 8'h30, 8'h32, 8'h35};
      for (int k = 0; k < 6; k++) thr[k] = RST[k];
      step(16);
      nrst = 1'b1;
      cv_active = 1'b1;
      // boundary then random ratios against reset thresholds
      for (int i = 0; i < 20; i++) begin
         ntc_ratio = (i < 12) ? RST[i / 2] + 16'(i % 2) : 16'($random(seed));
         {charging, absorb_active} = 2'($random(seed));
         step(2);
         rg = exp_region(ntc_ratio);
         check("region", 16'(region), 16'(rg));
         check("imv", 16'(imv), 16'(field(RST[8], RST[9], rg)) + 16'h0001);
      end
      charging = 1'b0;
      absorb_active = 1'b0;
      for (int a = 0; a < 17; a++) begin
         exp_q.push_back(RST[a]);
         i_i2c_host_model.read_reg(8'h1F + 8'(a));
      end
      for (int a = 0; a < 16; a++) begin
         wv[a] = 16'($random(seed));
         i_i2c_host_model.write_reg(DEV, 8'h1F + 8'(a), wv[a], nak);
      end
      // masked readback of reserved bits
      for (int a = 0; a < 16; a++) begin
         exp_q.push_back(wv[a] & MSK[a]);
         i_i2c_host_model.read_reg(8'h1F + 8'(a));
      end
      check("enables", 16'({en_cx, en_tc, en_jeita}), wv[10] & 16'h0007);
      check("abs add", 16'(abs_add), wv[11] & 16'h003F);
      check("abs lim", abs_lim, wv[12]);
      check("eq dur", eq_dur, wv[14]);
      check("eq add", 16'(eq_add), wv[13] & 16'h003F);
      check("recharge", rchg, wv[15]);
      for (int k = 0; k < 6; k++) thr[k] = wv[k];
      // written thresholds, then random ratios, against the written codes
      for (int i = 0; i < 8; i++) begin
         ntc_ratio = (i < 6) ? wv[i] : 16'($random(seed));
         step(2);
         rg = exp_region(ntc_ratio);
         check("region", 16'(region), 16'(rg));
         check("vcode", 16'(vcode), 16'(field(wv[6], wv[7], rg)));
         check("imv", 16'(imv), 16'(field(wv[8], wv[9], rg)) + 16'h0001);
         check("off", 16'(chg_off), 16'(wv[10][0] && (rg inside {3'h1, 3'h7})));
      end
      i_i2c_host_model.write_reg(DEV ^ 7'h01, 8'h20, ~wv[1], nak);
      check("addr nak", 16'(nak), 16'h0001);
      exp_q.push_back(wv[1]);
      i_i2c_host_model.read_reg(8'h20);
      // writes to reserved, timer and unmapped places are dropped
      for (int i = 0; i < 4; i++) begin
         i_i2c_host_model.write_reg(DEV, odd[i], 16'hFFFF, nak);
         exp_q.push_back(16'h0000);
         i_i2c_host_model.read_reg(odd[i]);
      end
      while (cyc < 66400) step(1);
      // elapsed_cv_seconds saturates rather than wrapping
      exp_q.push_back(16'hFFFF);
      i_i2c_host_model.read_reg(8'h31);
      cv_active = 1'b0;
      step(4);
      exp_q.push_back(16'h0000);
      i_i2c_host_model.read_reg(8'h31);
      step(4);
      results();
   end

   initial begin
      repeat (95000) @(posedge clk);
      n_mismatch++;
      results();
   end
endmodule
